// ==== design/bmu_map.svh ====
// Offsets, field positions, reset values and timing counts of the bit unit
// Included by bmu_top by bare name
`ifndef BMU_MAP_SVH
`define BMU_MAP_SVH

// Register port offsets (word index)
`define BMU_OFF_WORD0        8'h00
`define BMU_OFF_WORD1        8'h01
`define BMU_OFF_WORD2        8'h02
`define BMU_OFF_WORD3        8'h03
`define BMU_OFF_PROT0        8'h04
`define BMU_OFF_PROT1        8'h05
`define BMU_OFF_PROT2        8'h06
`define BMU_OFF_PROT3        8'h07
`define BMU_OFF_STATE        8'h08

// Reset values of the status words
`define BMU_RST_WORD0        16'h3800
`define BMU_RST_WORD1        16'h2920
`define BMU_RST_WORD2        16'h1000
`define BMU_RST_WORD3        16'h1C00

// Bits hidden behind the protected alias
`define BMU_PROT_WORD0       16'hE000
`define BMU_PROT_WORD1       16'h0420
`define BMU_PROT_WORD2       16'h0000
`define BMU_PROT_WORD3       16'hE0A0

// Field positions
`define BMU_TC_FIRST_BIT     4'hD
`define BMU_TC_SECOND_BIT    4'hC
`define BMU_MICRO_MODE_BIT   4'h6
`define BMU_CACHE_LOW_BIT    4'hD

// Opcode low nibbles that pick a status word
`define BMU_NIB_WORD0        4'h0
`define BMU_NIB_WORD1        4'h2
`define BMU_NIB_WORD2        4'h4
`define BMU_NIB_WORD3        4'h6

// Cycles taken by a cache-bit clear, and the end count of the strap load wait
`define BMU_FLUSH_CYCLES     5
`define BMU_STRAP_DELAY      2'h2

`endif

// ==== design/bmu_pkg.sv ====
// Types shared by the bit-manipulation unit
// Uses nothing from the map header
package bmu_pkg;

  typedef enum logic [2:0] {
    BMU_OP_NONE    = 3'h0,
    BMU_OP_MEM_CLR = 3'h1,
    BMU_OP_ST_CLR  = 3'h2,
    BMU_OP_COUNT   = 3'h3,
    BMU_OP_EXPAND  = 3'h4,
    BMU_OP_EXTRACT = 3'h5
  } bmu_op_e;

  typedef enum logic [1:0] {
    BMU_ST_RUN   = 2'b01,
    BMU_ST_FLUSH = 2'b10
  } bmu_state_e;

endpackage : bmu_pkg

// ==== design/bmu_field_unit.sv ====
// Shifter datapath: field expand, field extract and ones count
// Purely combinational; the caller registers the results
`timescale 1ns/1ns
`default_nettype none

module bmu_field_unit #(
  parameter int ACC_W  = 40,
  parameter int DATA_W = 16
) (
  input  wire logic [ACC_W-1:0]  acc_a,
  input  wire logic [ACC_W-1:0]  acc_b,
  input  wire logic [DATA_W-1:0] mask,
  output logic      [DATA_W-1:0] expand_out,
  output logic      [DATA_W-1:0] extract_out,
  output logic      [6:0]        ones_count
);

  initial
  begin
    if (ACC_W < DATA_W || ACC_W > 127 || DATA_W < 2 || DATA_W > 16)
      $error("bmu_field_unit: unsupported widths");
  end

  logic [4:0] rank [DATA_W];

  // Rank of each mask bit: set bits below it
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++)
    begin : g_bit
      if (gi == 0)
      begin : g_first
        assign rank[gi] = 5'h00;
      end
      else
      begin : g_rest
        assign rank[gi] = rank[gi-1] + {4'h0, mask[gi-1]};
      end
      assign expand_out[gi] = mask[gi] & acc_a[rank[gi]];
    end
  endgenerate

  always_comb
  begin
    extract_out = '0;
    for (int i = 0; i < DATA_W; i++)
    begin
      if (mask[i])
        extract_out[rank[i][3:0]] = acc_a[i];
    end
  end

  always_comb
  begin
    ones_count = 7'h00;
    for (int i = 0; i < ACC_W; i++)
      ones_count = ones_count + {6'h00, acc_a[i] & acc_b[i]};
  end

endmodule : bmu_field_unit

`default_nettype wire

// ==== design/bmu_flush_timer.sv ====
// Down counter that holds the unit busy during a pipeline flush
// Started by a one-cycle pulse from the same clock domain
`timescale 1ns/1ns
`default_nettype none

module bmu_flush_timer #(
  parameter int CYCLES = 5
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic start,
  output logic      done
);

  initial
  begin
    if (CYCLES < 2 || CYCLES > 15)
      $error("bmu_flush_timer: CYCLES out of range");
  end

  logic [3:0] count_q;
  logic [3:0] count_d;

  always_comb
  begin
    count_d = count_q;
    if (start)
      count_d = 4'(CYCLES - 1);
    else if (count_q != 4'h0)
      count_d = count_q - 4'h1;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      count_q <= 4'h0;
    else
      count_q <= count_d;
  end

  assign done = (count_q == 4'h1);

endmodule : bmu_flush_timer

`default_nettype wire

// ==== design/bmu_top.sv ====
// Bit-manipulation unit: memory bit clear, status bit clear, ones count,
// field expand and extract, plus the four status words and their port.
// Assumes a decoder that presents one operation per cycle while op_ready.
// How it works
// - memory clear zeroes the word bit named by source low four bits
// - memory clear runs under repeat and touches no status flag
// - status clear zeroes one bit of one of four status words
// - status clear is done in the address-side logic in one cycle
// - clearing word three bits 15 to 13 flushes and takes 5 cycles
// - status clear is refused under repeat; only the chosen bit changes
// - protected alias ignores writes and reads zero on marked bits
// - micro mode bit resets from a strap pin
// - ones count of the AND of two accumulators goes to temp
// - chosen test flag set when the count is odd, else cleared
// - count made in the shifter, moved by the address-side path
// - expand spreads low accumulator bits onto set mask positions
// - extract packs masked accumulator bits toward the low end
// - address-side destination gets the shifter result in one cycle
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

`include "bmu_map.svh"

module bmu_top
  import bmu_pkg::*;
#(
  parameter int ACC_W  = 40,
  parameter int DATA_W = 16
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [15:0]       reg_rdata,
  input  wire logic              op_valid,
  input  wire bmu_op_e           op_kind,
  input  wire logic [3:0]        op_low_nibble,
  input  wire logic [3:0]        bit_index_immediate,
  input  wire logic              op_repeat,
  input  wire logic [15:0]       op_source,
  input  wire logic [15:0]       op_mem_data,
  input  wire logic [ACC_W-1:0]  accumulator_a,
  input  wire logic [ACC_W-1:0]  accumulator_b,
  input  wire logic [DATA_W-1:0] field_mask_immediate,
  input  wire logic              op_dst_address_side,
  input  wire logic              micro_mode_pin,
  output logic                   op_ready,
  output logic                   op_refused,
  output logic                   pipe_flush,
  output logic      [15:0]       mem_wdata,
  output logic                   mem_write,
  output logic      [15:0]       temp_data,
  output logic                   temp_write,
  output logic      [DATA_W-1:0] au_bus_data,
  output logic                   au_bus_write,
  output logic      [DATA_W-1:0] du_result_data,
  output logic                   du_result_write,
  output logic      [15:0]       status_word_zero,
  output logic      [15:0]       status_word_one,
  output logic      [15:0]       status_word_two,
  output logic      [15:0]       status_word_three
);

  initial
  begin
    if (DATA_W != 16)
      $error("bmu_top: DATA_W must be 16");
  end

  // Status words and bus read path
  logic [15:0] word_q [4];
  logic [15:0] word_d [4];
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // Operation results
  logic [15:0]       mem_wdata_q,  mem_wdata_d;
  logic              mem_write_q,  mem_write_d;
  logic [15:0]       temp_data_q,  temp_data_d;
  logic              temp_write_q, temp_write_d;
  logic [DATA_W-1:0] au_data_q,    au_data_d;
  logic              au_write_q,   au_write_d;
  logic [DATA_W-1:0] du_data_q,    du_data_d;
  logic              du_write_q,   du_write_d;
  logic              refused_q,    refused_d;
  logic              flush_q,      flush_d;
  logic [6:0]        last_count_q, last_count_d;

  bmu_state_e state_q;
  bmu_state_e state_d;

  // Strap capture
  logic       strap_meta_q;
  logic       strap_sync_q;
  logic [1:0] strap_wait_q;
  logic [1:0] strap_wait_d;
  logic       strap_load;

  logic [DATA_W-1:0] expand_out;
  logic [DATA_W-1:0] extract_out;
  logic [6:0]        ones_count;
  logic              flush_done;
  logic              accept;
  logic              sel_ok;
  logic [1:0]        sel;
  logic [15:0]       prot_mask [4];

  assign prot_mask[0] = `BMU_PROT_WORD0;
  assign prot_mask[1] = `BMU_PROT_WORD1;
  assign prot_mask[2] = `BMU_PROT_WORD2;
  assign prot_mask[3] = `BMU_PROT_WORD3;

  bmu_field_unit #(
    .ACC_W  (ACC_W),
    .DATA_W (DATA_W)
  ) u_field (
    .acc_a       (accumulator_a),
    .acc_b       (accumulator_b),
    .mask        (field_mask_immediate),
    .expand_out  (expand_out),
    .extract_out (extract_out),
    .ones_count  (ones_count)
  );

  bmu_flush_timer #(
    .CYCLES (`BMU_FLUSH_CYCLES)
  ) u_flush (
    .clock (clock),
    .reset (reset),
    .start (flush_d),
    .done  (flush_done)
  );

  assign op_ready = (state_q == BMU_ST_RUN);
  assign accept   = op_valid && op_ready;

  // Status word select from opcode low nibble
  always_comb
  begin
    sel_ok = 1'b1;
    case (op_low_nibble)
      `BMU_NIB_WORD0: sel = 2'h0;
      `BMU_NIB_WORD1: sel = 2'h1;
      `BMU_NIB_WORD2: sel = 2'h2;
      `BMU_NIB_WORD3: sel = 2'h3;
      default:
      begin
        sel    = 2'h0;
        sel_ok = 1'b0;
      end
    endcase
  end

  // Pin strap passes two flops, loaded two edges after reset release
  always_ff @(posedge clock)
  begin
    strap_meta_q <= micro_mode_pin;
    strap_sync_q <= strap_meta_q;
  end

  always_comb
  begin
    strap_wait_d = strap_wait_q;
    if (strap_wait_q != `BMU_STRAP_DELAY)
      strap_wait_d = strap_wait_q + 2'h1;
  end

  assign strap_load = (strap_wait_q == 2'h1);

  // Operation state machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      BMU_ST_RUN:
        if (flush_d)
          state_d = BMU_ST_FLUSH;
      BMU_ST_FLUSH:
        if (flush_done)
          state_d = BMU_ST_RUN;
      default:
        state_d = BMU_ST_RUN;
    endcase
  end

  // Datapath and status word next values
  always_comb
  begin
    for (int w = 0; w < 4; w++)
      word_d[w] = word_q[w];
    mem_wdata_d  = mem_wdata_q;
    mem_write_d  = 1'b0;
    temp_data_d  = temp_data_q;
    temp_write_d = 1'b0;
    au_data_d    = au_data_q;
    au_write_d   = 1'b0;
    du_data_d    = du_data_q;
    du_write_d   = 1'b0;
    refused_d    = 1'b0;
    flush_d      = 1'b0;
    last_count_d = last_count_q;

    if (strap_load)
      word_d[3][`BMU_MICRO_MODE_BIT] = strap_sync_q;

    // Software writes; the protected alias keeps marked bits
    if (reg_write)
    begin
      if (reg_addr[7:2] == `BMU_OFF_WORD0 >> 2)
        word_d[reg_addr[1:0]] = reg_wdata;
      else if (reg_addr[7:2] == `BMU_OFF_PROT0 >> 2)
        word_d[reg_addr[1:0]] = (reg_wdata & ~prot_mask[reg_addr[1:0]])
                              | (word_q[reg_addr[1:0]] & prot_mask[reg_addr[1:0]]);
    end

    // Hardware updates land on top of a same-cycle software write
    if (accept)
    begin
      case (op_kind)
        BMU_OP_MEM_CLR:
        begin
          mem_wdata_d = op_mem_data & ~(16'h0001 << op_source[3:0]);
          mem_write_d = 1'b1;
        end
        BMU_OP_ST_CLR:
        begin
          if (op_repeat || !sel_ok)
            refused_d = 1'b1;
          else
          begin
            word_d[sel][bit_index_immediate] = 1'b0;
            if (sel == 2'h3 && bit_index_immediate >= `BMU_CACHE_LOW_BIT)
              flush_d = 1'b1;
          end
        end
        BMU_OP_COUNT:
        begin
          temp_data_d  = {9'h000, ones_count};
          temp_write_d = 1'b1;
          last_count_d = ones_count;
          if (op_low_nibble[0])
            word_d[0][`BMU_TC_SECOND_BIT] = ones_count[0];
          else
            word_d[0][`BMU_TC_FIRST_BIT] = ones_count[0];
        end
        BMU_OP_EXPAND, BMU_OP_EXTRACT:
        begin
          if (op_dst_address_side)
          begin
            au_data_d  = (op_kind == BMU_OP_EXPAND) ? expand_out : extract_out;
            au_write_d = 1'b1;
          end
          else
          begin
            du_data_d  = (op_kind == BMU_OP_EXPAND) ? expand_out : extract_out;
            du_write_d = 1'b1;
          end
        end
        default:
        begin
          refused_d = 1'b0;
        end
      endcase
    end
  end

  // Bus read, answered in the next cycle
  always_comb
  begin
    rdata_d = 16'h0000;
    if (reg_read)
    begin
      if (reg_addr[7:2] == `BMU_OFF_WORD0 >> 2)
        rdata_d = word_q[reg_addr[1:0]];
      else if (reg_addr[7:2] == `BMU_OFF_PROT0 >> 2)
        rdata_d = word_q[reg_addr[1:0]] & ~prot_mask[reg_addr[1:0]];
      else if (reg_addr == `BMU_OFF_STATE)
        rdata_d = {state_q == BMU_ST_FLUSH, 8'h00, last_count_q};
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      word_q[0]    <= `BMU_RST_WORD0;
      word_q[1]    <= `BMU_RST_WORD1;
      word_q[2]    <= `BMU_RST_WORD2;
      word_q[3]    <= `BMU_RST_WORD3;
      rdata_q      <= 16'h0000;
      mem_wdata_q  <= 16'h0000;
      mem_write_q  <= 1'b0;
      temp_data_q  <= 16'h0000;
      temp_write_q <= 1'b0;
      au_data_q    <= '0;
      au_write_q   <= 1'b0;
      du_data_q    <= '0;
      du_write_q   <= 1'b0;
      refused_q    <= 1'b0;
      flush_q      <= 1'b0;
      last_count_q <= 7'h00;
      state_q      <= BMU_ST_RUN;
      strap_wait_q <= 2'h0;
    end
    else
    begin
      for (int w = 0; w < 4; w++)
        word_q[w] <= word_d[w];
      rdata_q      <= rdata_d;
      mem_wdata_q  <= mem_wdata_d;
      mem_write_q  <= mem_write_d;
      temp_data_q  <= temp_data_d;
      temp_write_q <= temp_write_d;
      au_data_q    <= au_data_d;
      au_write_q   <= au_write_d;
      du_data_q    <= du_data_d;
      du_write_q   <= du_write_d;
      refused_q    <= refused_d;
      flush_q      <= flush_d;
      last_count_q <= last_count_d;
      state_q      <= state_d;
      strap_wait_q <= strap_wait_d;
    end
  end

  assign reg_rdata         = rdata_q;
  assign op_refused        = refused_q;
  assign pipe_flush        = flush_q;
  assign mem_wdata         = mem_wdata_q;
  assign mem_write         = mem_write_q;
  assign temp_data         = temp_data_q;
  assign temp_write        = temp_write_q;
  assign au_bus_data       = au_data_q;
  assign au_bus_write      = au_write_q;
  assign du_result_data    = du_data_q;
  assign du_result_write   = du_write_q;
  assign status_word_zero  = word_q[0];
  assign status_word_one   = word_q[1];
  assign status_word_two   = word_q[2];
  assign status_word_three = word_q[3];

endmodule : bmu_top

`default_nettype wire

// ==== dv/bmu_chk.sv ====
// Assertions on the bit unit's operation port
// Bound onto bmu_top; one clock, synchronous reset
`timescale 1ns/1ns
`default_nettype none

module bmu_chk
  import bmu_pkg::*;
#(
  parameter int ACC_W  = 40,
  parameter int DATA_W = 16
) (
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              reg_write,
  input wire logic              op_valid,
  input wire bmu_op_e           op_kind,
  input wire logic [3:0]        op_low_nibble,
  input wire logic [3:0]        bit_index_immediate,
  input wire logic              op_repeat,
  input wire logic [15:0]       op_source,
  input wire logic [15:0]       op_mem_data,
  input wire logic [ACC_W-1:0]  accumulator_a,
  input wire logic [ACC_W-1:0]  accumulator_b,
  input wire logic              op_dst_address_side,
  input wire logic              op_ready,
  input wire logic              op_refused,
  input wire logic              pipe_flush,
  input wire logic [15:0]       mem_wdata,
  input wire logic              mem_write,
  input wire logic [15:0]       temp_data,
  input wire logic              temp_write,
  input wire logic              au_bus_write,
  input wire logic              du_result_write,
  input wire logic [15:0]       status_word_zero,
  input wire logic [15:0]       status_word_three
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  logic take;
  assign take = op_valid && op_ready && !reg_write;

  property p_mem_clr;
    take && op_kind == BMU_OP_MEM_CLR
    |=> mem_write && mem_wdata == ($past(op_mem_data) & ~(16'h1 << $past(op_source[3:0])));
  endproperty
  a_mem_clr: assert property (p_mem_clr) else $error("memory clear result wrong");

  property p_mem_quiet;
    take && op_kind == BMU_OP_MEM_CLR |=> $stable(status_word_zero) && $stable(status_word_three);
  endproperty
  a_mem_quiet: assert property (p_mem_quiet) else $error("memory clear touched status");

  property p_st_clr;
    take && op_kind == BMU_OP_ST_CLR && op_low_nibble == 4'h0 && !op_repeat
    |=> status_word_zero == ($past(status_word_zero) & ~(16'h1 << $past(bit_index_immediate)));
  endproperty
  a_st_clr: assert property (p_st_clr) else $error("status clear wrong");

  property p_refuse;
    take && op_kind == BMU_OP_ST_CLR && op_repeat
    |=> op_refused && !pipe_flush && $stable(status_word_three) && $stable(status_word_zero);
  endproperty
  a_refuse: assert property (p_refuse) else $error("repeated status clear not refused");

  property p_flush;
    take && op_kind == BMU_OP_ST_CLR && op_low_nibble == 4'h6 && bit_index_immediate >= 4'hD
    && !op_repeat |=> pipe_flush && !op_ready ##1 !op_ready [*3] ##1 op_ready;
  endproperty
  a_flush: assert property (p_flush) else $error("cache clear timing wrong");

  property p_count;
    take && op_kind == BMU_OP_COUNT
    |=> temp_write && temp_data == 16'($countones($past(accumulator_a) & $past(accumulator_b)));
  endproperty
  a_count: assert property (p_count) else $error("ones count wrong");

  property p_parity;
    take && op_kind == BMU_OP_COUNT && !op_low_nibble[0] |=> status_word_zero[13] == temp_data[0];
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");

  property p_au_bus;
    take && op_kind == BMU_OP_EXPAND && op_dst_address_side |=> au_bus_write && !du_result_write;
  endproperty
  a_au_bus: assert property (p_au_bus) else $error("expand not on dedicated bus");

  c_flush: cover property (pipe_flush);
  c_odd: cover property (temp_write && temp_data[0]);
  c_refuse: cover property (op_refused);
endmodule : bmu_chk

bind bmu_top bmu_chk #(.ACC_W(ACC_W), .DATA_W(DATA_W)) bmu_chk_i (
  .clock(clock), .reset(reset), .reg_write(reg_write), .op_valid(op_valid),
  .op_kind(op_kind), .op_low_nibble(op_low_nibble), .bit_index_immediate(bit_index_immediate),
  .op_repeat(op_repeat), .op_source(op_source), .op_mem_data(op_mem_data),
  .accumulator_a(accumulator_a), .accumulator_b(accumulator_b),
  .op_dst_address_side(op_dst_address_side), .op_ready(op_ready), .op_refused(op_refused),
  .pipe_flush(pipe_flush), .mem_wdata(mem_wdata), .mem_write(mem_write),
  .temp_data(temp_data), .temp_write(temp_write), .au_bus_write(au_bus_write),
  .du_result_write(du_result_write), .status_word_zero(status_word_zero),
  .status_word_three(status_word_three));

`default_nettype wire

// ==== dv/bmu_mem_model.sv ====
// Data memory of four words seen by the memory bit clear
// Write lands at the address latched when the op was presented
`timescale 1ns/1ns
`default_nettype none

module bmu_mem_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        op_valid,
  input  wire logic [1:0]  addr,
  input  wire logic        mem_write,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] rdata
);
  logic [15:0] mem_q [4];
  logic [1:0]  waddr_q;

  assign rdata = mem_q[addr];

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      for (int k = 0; k < 4; k++) mem_q[k] <= 16'hFFFF;
    end
    else
    begin
      if (op_valid) waddr_q <= addr;
      if (mem_write) mem_q[waddr_q] <= mem_wdata;
    end
  end
endmodule : bmu_mem_model

`default_nettype wire

// ==== dv/bmu_top_tb.sv ====
// Self-checking bench for the bit unit
// Drives register and operation ports; memory model on the far side
`timescale 1ns/1ns
`default_nettype none

module bmu_top_tb;
  import bmu_pkg::*;
  logic clock, reset, reg_write, reg_read, op_valid, op_repeat, dst_au, pin;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, op_source, mem_data, mask;
  logic [3:0]  op_nib, op_idx;
  logic [1:0]  mem_addr;
  logic [39:0] acc_a, acc_b;
  bmu_op_e     op_kind;
  logic        op_ready, op_refused, pipe_flush, mem_write, temp_write, au_write, du_write;
  logic [15:0] mem_wdata, temp_data, au_data, du_data, sw0, sw1, sw2, sw3;
  int          failures, checks_done;

  bmu_top bmu_top_i (.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .op_valid(op_valid),
    .op_kind(op_kind), .op_low_nibble(op_nib), .bit_index_immediate(op_idx),
    .op_repeat(op_repeat), .op_source(op_source), .op_mem_data(mem_data),
    .accumulator_a(acc_a), .accumulator_b(acc_b), .field_mask_immediate(mask),
    .op_dst_address_side(dst_au), .micro_mode_pin(pin), .op_ready(op_ready),
    .op_refused(op_refused), .pipe_flush(pipe_flush), .mem_wdata(mem_wdata),
    .mem_write(mem_write), .temp_data(temp_data), .temp_write(temp_write),
    .au_bus_data(au_data), .au_bus_write(au_write), .du_result_data(du_data),
    .du_result_write(du_write), .status_word_zero(sw0), .status_word_one(sw1),
    .status_word_two(sw2), .status_word_three(sw3));

  bmu_mem_model bmu_mem_model_i (.clock(clock), .reset(reset), .op_valid(op_valid),
    .addr(mem_addr), .mem_write(mem_write), .mem_wdata(mem_wdata), .rdata(mem_data));

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  // Presents one op; returns in the cycle its results stand
  task automatic op(input bmu_op_e k, input logic [3:0] n, input logic [3:0] i, input logic r);
    @(posedge clock);
    op_valid <= 1'b1;
    op_kind <= k;
    op_nib <= n;
    op_idx <= i;
    op_repeat <= r;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
  endtask : op

  initial
  begin
    static logic [3:0]  idx [4] = '{4'hB, 4'hD, 4'hC, 4'hC};
    static logic [15:0] wexp [4] = '{16'h3000, 16'h0920, 16'h0000, 16'h0C40};
    static logic [39:0] ca [3] = '{40'h3, 40'h7E23554FC0, 40'hF};
    static logic [39:0] cb [3] = '{40'h3, 40'h0FE3405678, 40'h5};
    static logic [15:0] cn [3] = '{16'h2, 16'hB, 16'h2};
    static logic [15:0] cw [3] = '{16'h1000, 16'h3000, 16'h2000};
    {reg_write, reg_read, op_valid, op_repeat, dst_au, reg_addr, reg_wdata} = '0;
    {op_source, mask, op_nib, op_idx, mem_addr, acc_a, acc_b} = '0;
    op_kind = BMU_OP_NONE;
    pin = 1'b1;
    reset = 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd(8'h00, 16'h3800);
    rd(8'h01, 16'h2920);
    rd(8'h02, 16'h1000);
    rd(8'h03, 16'h1C40);
    rd(8'h20, 16'h0000);
    for (int k = 0; k < 4; k++)
    begin
      op(BMU_OP_ST_CLR, 4'(2 * k), idx[k], 1'b0);
      rd(8'(k), wexp[k]);
    end
    op(BMU_OP_ST_CLR, 4'h1, 4'hF, 1'b0);
    chk(op_refused, 1'b1);
    op(BMU_OP_ST_CLR, 4'h6, 4'h6, 1'b1);
    chk(op_refused, 1'b1);
    rd(8'h03, 16'h0C40);
    wr(8'h05, 16'hFFFF);
    rd(8'h01, 16'hFBFF);
    rd(8'h05, 16'hFBDF);
    chk(sw1, 16'hFBFF);
    wr(8'h03, 16'hEC40);
    op(BMU_OP_ST_CLR, 4'h6, 4'hE, 1'b0);
    chk(pipe_flush, 1'b1);
    chk(op_ready, 1'b0);
    repeat (3)
    begin
      @(posedge clock);
      #1;
      chk(op_ready, 1'b0);
    end
    @(posedge clock);
    #1;
    chk(op_ready, 1'b1);
    rd(8'h03, 16'hAC40);
    chk(sw3, 16'hAC40);
    @(posedge clock);
    mem_addr <= 2'h1;
    op_source <= 16'h000F;
    op(BMU_OP_MEM_CLR, 4'h0, 4'h0, 1'b1);
    chk(mem_wdata, 16'h7FFF);
    chk(mem_write, 1'b1);
    @(posedge clock);
    op_source <= 16'hFFF0;
    op(BMU_OP_MEM_CLR, 4'h0, 4'h0, 1'b0);
    chk(mem_wdata, 16'h7FFE);
    @(posedge clock);
    #1;
    chk(mem_data, 16'h7FFE);
    chk(sw0, 16'h3000);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clock);
      acc_a <= ca[k];
      acc_b <= cb[k];
      op(BMU_OP_COUNT, 4'(k / 2), 4'h0, 1'b0);
      chk(temp_data, cn[k]);
      chk(temp_write, 1'b1);
      chk(sw0, cw[k]);
    end
    rd(8'h08, 16'h0002);
    chk(sw2, 16'h0000);
    @(posedge clock);
    mask <= 16'h8024;
    acc_a <= 40'h0023002B65;
    dst_au <= 1'b1;
    op(BMU_OP_EXPAND, 4'h0, 4'h0, 1'b0);
    chk(au_data, 16'h8004);
    chk({au_write, du_write}, 16'h2);
    @(posedge clock);
    acc_a <= 40'h00230055AA;
    dst_au <= 1'b0;
    op(BMU_OP_EXTRACT, 4'h0, 4'h0, 1'b0);
    chk(du_data, 16'h0002);
    chk({au_write, du_write}, 16'h1);
    conclude();
  end

  initial
  begin
    repeat (3000) @(posedge clock);
    failures++;
    conclude();
  end
endmodule : bmu_top_tb

`default_nettype wire
